// ===== elx_pkg.sv
// Constants, opcodes, cycle budgets and state type of the execution unit
// that runs external-data moves, the no-operation and the AND/OR forms.
// Assumes a single 100 MHz core clock and a synchronous active-low reset.
package elx_pkg;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OPC_EXT_LOAD = 8'h82;
  localparam logic [7:0] OPC_EXT_STORE = 8'h92;
  localparam logic [7:0] OPC_EXT_LOAD_INC = 8'h83;
  localparam logic [7:0] OPC_EXT_STORE_INC = 8'h93;
  localparam logic [3:0] OPC_AND_HI = 4'h4;
  localparam logic [3:0] OPC_OR_HI = 4'h0;
  localparam logic [3:0] MODE_RR = 4'h2;
  localparam logic [3:0] MODE_WORK_IND = 4'h3;
  localparam logic [3:0] MODE_REG_REG = 4'h4;
  localparam logic [3:0] MODE_REG_IND = 4'h5;
  localparam logic [3:0] MODE_REG_IMM = 4'h6;
  localparam logic [3:0] MODE_IND_IMM = 4'h7;
  localparam logic [3:0] WORK_ESCAPE = 4'he;

  // ==========================================================================
  // Cycle budgets per instruction
  localparam logic [4:0] CYC_EXT = 5'h0c;
  localparam logic [4:0] CYC_EXT_AUTOINC = 5'h12;
  localparam logic [4:0] CYC_LOGIC_WORK = 5'h06;
  localparam logic [4:0] CYC_LOGIC_REG = 5'h0a;
  localparam logic [4:0] CYC_NOP = 5'h06;
  localparam logic [4:0] CYC_ILLEGAL = 5'h01;

  // ==========================================================================
  // External data memory timing: cycles from read strobe to data capture
  localparam logic [2:0] EXT_RD_WAIT = 3'h4;

  // ==========================================================================
  // Flag bit positions and reset values
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_S = 2;
  localparam int FLG_V = 3;
  localparam int FLG_D = 4;
  localparam int FLG_H = 5;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [4:0] CNT_RST = 5'h00;

  typedef enum logic [4:0] {
    ST_IDLE, ST_DPTR, ST_DLAT, ST_SPTR, ST_SVAL, ST_DVAL, ST_WR,
    ST_PHI, ST_PLO, ST_RPTR, ST_PVAL, ST_PDAT, ST_XRD, ST_XWAIT, ST_XWR,
    ST_WRF, ST_INCR, ST_INCLO, ST_INCHI, ST_HOLD
  } elx_state_t;

endpackage : elx_pkg

// ===== elx_regfile.sv
// Byte-wide register file with one write port and one registered read port.
// Assumes both ports are driven from the core clock domain.
module elx_regfile #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Write port
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  if (WIDTH < 1 || DEPTH < 2) begin : g_bad_size
    $error("elx_regfile: WIDTH and DEPTH too small");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage carries no reset: contents are software state
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule : elx_regfile

// ===== elx_exec.sv
// Execution unit for external-data byte moves (plain and auto-increment),
// the no-operation and the AND/OR logic forms, with its own register file.
// Assumes the sequencer issues one instruction at a time on the core clock
// and that external data memory answers a read with a fixed latency.
// Behaviour
// - Opcode 82 loads external byte, 12 cycles
// - Opcode 92 stores working register, 12 cycles
// - External address from even/odd working pair
// - Opcode 83 loads into pointed register, 18 cycles
// - Opcode 93 stores pointed register, 18 cycles
// - Auto-increment bumps pointer and pair, no flags
// - External moves only on external-capable variants
// - No-operation changes no register or flag
// - AND result replaces destination, source kept
// - AND opcodes 42-47, 6 or 10 cycles
// - OR result replaces destination, source kept
// - OR opcodes 02-07, 6 or 10 cycles
// - Zero flag from result, overflow cleared
// - Sign is bit 7; C, D, H kept
// - High nibble Eh selects working register
// - Register-register form: source byte, then destination
module elx_exec
  import elx_pkg::*;
#(
  parameter bit EXT_DATA_EN = 1'b1,
  parameter logic [7:0] NOP_OPC = 8'hff
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Instruction issue
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [7:0] instr_opc,
  input wire logic [7:0] instr_b1,
  input wire logic [7:0] instr_b2,
  input wire logic [3:0] work_ptr,
  output logic instr_done,
  output logic instr_illegal,
  // Flags
  output logic [5:0] flags,
  input wire logic flags_we,
  input wire logic [5:0] flags_wdata,
  // Register file side access, idle only
  input wire logic dbg_we,
  input wire logic [7:0] dbg_addr,
  input wire logic [7:0] dbg_wdata,
  output logic [7:0] dbg_rdata,
  // External data memory
  output logic [15:0] ext_addr,
  output logic ext_rd,
  output logic ext_wr,
  output logic [7:0] ext_wdata,
  input wire logic [7:0] ext_rdata
);

  // ==========================================================================
  // Operand decoding
  function automatic logic [7:0] work_addr(input logic [3:0] rp, input logic [3:0] n);
    return {rp, n};
  endfunction : work_addr

  function automatic logic [7:0] reg_addr(input logic [3:0] rp, input logic [7:0] b);
    return (b[7:4] == WORK_ESCAPE) ? {rp, b[3:0]} : b;
  endfunction : reg_addr

  elx_state_t state_q, state_d;
  logic [4:0] cnt_q, cyc_q;
  logic [7:0] opc_q, dst_addr_q, src_addr_q, src_val_q, ptr_q, xdat_q, xhi_q, xlo_q;
  logic [3:0] rn_q, pair_q;
  logic [2:0] wait_q;
  logic [5:0] flags_q;
  logic done_q, ill_q, ext_rd_q, ext_wr_q;
  logic [15:0] ext_addr_q;
  logic [7:0] ext_wdata_q, ext_sync1_q, ext_sync2_q;

  // ==========================================================================
  // Instruction classification
  wire accept = instr_valid && (state_q == ST_IDLE);
  wire [3:0] mode = instr_opc[3:0];
  wire is_logic = (instr_opc[7:4] == OPC_AND_HI || instr_opc[7:4] == OPC_OR_HI)
                  && (mode >= MODE_RR) && (mode <= MODE_IND_IMM);
  wire is_ext_opc = (instr_opc == OPC_EXT_LOAD) || (instr_opc == OPC_EXT_STORE)
                    || (instr_opc == OPC_EXT_LOAD_INC) || (instr_opc == OPC_EXT_STORE_INC);
  wire is_ext = is_ext_opc && EXT_DATA_EN;
  wire is_nop = (instr_opc == NOP_OPC);
  wire is_work_form = (mode == MODE_RR) || (mode == MODE_WORK_IND);
  wire autoinc = (opc_q == OPC_EXT_LOAD_INC) || (opc_q == OPC_EXT_STORE_INC);
  wire op_and = (opc_q[7:4] == OPC_AND_HI);

  // ==========================================================================
  // Register file access
  logic rf_we;
  logic [7:0] rf_waddr, rf_wdata, rf_raddr, rf_rdata;
  wire [7:0] logic_res = op_and ? (rf_rdata & src_val_q) : (rf_rdata | src_val_q);
  wire [15:0] pair_inc = {xhi_q, xlo_q} + 16'h0001;
  wire [7:0] ptr_inc = ptr_q + 8'h01;
  wire [3:0] pair_hi = {pair_q[3:1], 1'b0};
  wire [3:0] pair_lo = {pair_q[3:1], 1'b1};

  always_comb begin
    rf_raddr = dbg_addr;
    rf_we = 1'b0;
    rf_waddr = dbg_addr;
    rf_wdata = dbg_wdata;
    case (state_q)
      ST_IDLE: begin
        rf_we = dbg_we;
      end
      ST_DPTR: rf_raddr = dst_addr_q;
      ST_SPTR: rf_raddr = src_addr_q;
      ST_SVAL: rf_raddr = (opc_q[3:0] == MODE_WORK_IND || opc_q[3:0] == MODE_REG_IND)
                          ? rf_rdata : src_addr_q;
      ST_DVAL: rf_raddr = dst_addr_q;
      ST_WR: begin
        rf_we = 1'b1;
        rf_waddr = dst_addr_q;
        rf_wdata = logic_res;
      end
      ST_PHI: rf_raddr = work_addr(work_ptr, pair_hi);
      ST_PLO: rf_raddr = work_addr(work_ptr, pair_lo);
      ST_RPTR: rf_raddr = work_addr(work_ptr, rn_q);
      ST_PVAL: rf_raddr = rf_rdata;
      ST_WRF: begin
        rf_we = 1'b1;
        rf_waddr = autoinc ? ptr_q : work_addr(work_ptr, rn_q);
        rf_wdata = xdat_q;
      end
      ST_INCR: begin
        rf_we = 1'b1;
        rf_waddr = work_addr(work_ptr, rn_q);
        rf_wdata = ptr_inc;
      end
      ST_INCLO: begin
        rf_we = 1'b1;
        rf_waddr = work_addr(work_ptr, pair_lo);
        rf_wdata = pair_inc[7:0];
      end
      ST_INCHI: begin
        rf_we = 1'b1;
        rf_waddr = work_addr(work_ptr, pair_hi);
        rf_wdata = pair_inc[15:8];
      end
      default: begin
        rf_we = 1'b0;
      end
    endcase
  end

  elx_regfile #(.WIDTH(8), .DEPTH(256)) u_rf (
    .clk(clk),
    .rstn(rstn),
    .we(rf_we),
    .waddr(rf_waddr),
    .wdata(rf_wdata),
    .raddr(rf_raddr),
    .rdata(rf_rdata)
  );

  // ==========================================================================
  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          if (is_ext) begin
            state_d = ST_PHI;
          end else if (is_logic) begin
            if (mode == MODE_IND_IMM) begin
              state_d = ST_DPTR;
            end else if (mode == MODE_REG_IMM) begin
              state_d = ST_DVAL;
            end else if (mode == MODE_WORK_IND || mode == MODE_REG_IND) begin
              state_d = ST_SPTR;
            end else begin
              state_d = ST_SVAL;
            end
          end else begin
            state_d = ST_HOLD;
          end
        end
      end
      ST_DPTR: state_d = ST_DLAT;
      ST_DLAT: state_d = ST_DVAL;
      ST_SPTR: state_d = ST_SVAL;
      ST_SVAL: state_d = ST_DVAL;
      ST_DVAL: state_d = ST_WR;
      ST_WR: state_d = ST_HOLD;
      ST_PHI: state_d = ST_PLO;
      ST_PLO: state_d = ST_RPTR;
      ST_RPTR: state_d = (opc_q == OPC_EXT_LOAD) ? ST_XRD : ST_PVAL;
      ST_PVAL: begin
        if (opc_q == OPC_EXT_STORE) begin
          state_d = ST_XWR;
        end else if (opc_q == OPC_EXT_LOAD_INC) begin
          state_d = ST_XRD;
        end else begin
          state_d = ST_PDAT;
        end
      end
      ST_PDAT: state_d = ST_XWR;
      ST_XRD: state_d = ST_XWAIT;
      ST_XWAIT: state_d = (wait_q == EXT_RD_WAIT) ? ST_WRF : ST_XWAIT;
      ST_WRF: state_d = autoinc ? ST_INCR : ST_HOLD;
      ST_XWR: state_d = autoinc ? ST_INCR : ST_HOLD;
      ST_INCR: state_d = ST_INCLO;
      ST_INCLO: state_d = ST_INCHI;
      ST_INCHI: state_d = ST_HOLD;
      ST_HOLD: state_d = (cnt_q >= cyc_q) ? ST_IDLE : ST_HOLD;
      default: state_d = ST_IDLE;
    endcase
  end

  // Budget per accepted instruction
  logic [4:0] cyc_new;
  always_comb begin
    if (is_ext) begin
      cyc_new = (instr_opc[0]) ? CYC_EXT_AUTOINC : CYC_EXT;
    end else if (is_logic) begin
      cyc_new = is_work_form ? CYC_LOGIC_WORK : CYC_LOGIC_REG;
    end else if (is_nop) begin
      cyc_new = CYC_NOP;
    end else begin
      cyc_new = CYC_ILLEGAL;
    end
  end

  // ==========================================================================
  // Sequencer registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_RST;
      cyc_q <= CNT_RST;
      done_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      state_q <= state_d;
      done_q <= (state_q == ST_HOLD) && (state_d == ST_IDLE);
      if (accept) begin
        cnt_q <= 5'h01;
        cyc_q <= cyc_new;
        ill_q <= !(is_ext || is_logic || is_nop);
      end else if (state_q != ST_IDLE) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // ==========================================================================
  // Operand capture; ordering of operand bytes follows the form
  always_ff @(posedge clk) begin
    if (!rstn) begin
      opc_q <= BYTE_RST;
      dst_addr_q <= BYTE_RST;
      src_addr_q <= BYTE_RST;
      src_val_q <= BYTE_RST;
      rn_q <= 4'h0;
      pair_q <= 4'h0;
    end else if (accept) begin
      opc_q <= instr_opc;
      rn_q <= instr_b1[7:4];
      pair_q <= instr_b1[3:0];
      src_val_q <= instr_b2;
      if (is_work_form) begin
        dst_addr_q <= work_addr(work_ptr, instr_b1[7:4]);
        src_addr_q <= work_addr(work_ptr, instr_b1[3:0]);
      end else if (mode == MODE_REG_REG || mode == MODE_REG_IND) begin
        src_addr_q <= reg_addr(work_ptr, instr_b1);
        dst_addr_q <= reg_addr(work_ptr, instr_b2);
      end else begin
        dst_addr_q <= reg_addr(work_ptr, instr_b1);
      end
    end else begin
      if (state_q == ST_DLAT) begin
        dst_addr_q <= rf_rdata;
      end
      if (state_q == ST_DVAL && !(opc_q[3:0] == MODE_REG_IMM || opc_q[3:0] == MODE_IND_IMM)) begin
        src_val_q <= rf_rdata;
      end
    end
  end

  // Logic source operand never written back: ST_WR writes only dst_addr_q
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags_q <= FLAGS_RST;
    end else if (state_q == ST_WR) begin
      flags_q[FLG_Z] <= (logic_res == 8'h00);
      flags_q[FLG_V] <= 1'b0;
      flags_q[FLG_S] <= logic_res[7];
    end else if (state_q == ST_IDLE && flags_we) begin
      flags_q <= flags_wdata;
    end
  end

  // ==========================================================================
  // External transfer datapath
  always_ff @(posedge clk) begin
    if (!rstn) begin
      xhi_q <= BYTE_RST;
      xlo_q <= BYTE_RST;
      ptr_q <= BYTE_RST;
      xdat_q <= BYTE_RST;
      wait_q <= 3'h0;
    end else begin
      if (state_q == ST_PLO) begin
        xhi_q <= rf_rdata;
      end
      if (state_q == ST_RPTR) begin
        xlo_q <= rf_rdata;
      end
      if (state_q == ST_PVAL) begin
        ptr_q <= rf_rdata;
        xdat_q <= rf_rdata;
      end
      if (state_q == ST_PDAT) begin
        xdat_q <= rf_rdata;
      end
      wait_q <= (state_q == ST_XWAIT) ? wait_q + 3'h1 : 3'h0;
      if (state_q == ST_XWAIT && wait_q == EXT_RD_WAIT) begin
        xdat_q <= ext_sync2_q;
      end
    end
  end

  // Read data arrives from pins; two flops before use
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ext_sync1_q <= BYTE_RST;
      ext_sync2_q <= BYTE_RST;
    end else begin
      ext_sync1_q <= ext_rdata;
      ext_sync2_q <= ext_sync1_q;
    end
  end

  // Strobes last one cycle; address and data hold until the next transfer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ext_rd_q <= 1'b0;
      ext_wr_q <= 1'b0;
      ext_addr_q <= 16'h0000;
      ext_wdata_q <= BYTE_RST;
    end else begin
      ext_rd_q <= (state_q == ST_XRD);
      ext_wr_q <= (state_q == ST_XWR);
      if (state_q == ST_XRD || state_q == ST_XWR) begin
        ext_addr_q <= {xhi_q, xlo_q};
      end
      if (state_q == ST_XWR) begin
        ext_wdata_q <= xdat_q;
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign instr_ready = (state_q == ST_IDLE);
  assign instr_done = done_q;
  assign instr_illegal = ill_q;
  assign flags = flags_q;
  assign dbg_rdata = rf_rdata;
  assign ext_addr = ext_addr_q;
  assign ext_rd = ext_rd_q;
  assign ext_wr = ext_wr_q;
  assign ext_wdata = ext_wdata_q;

endmodule : elx_exec

// ===== elx_exec_checker.sv
// Concurrent checks on the issue, flag and external strobe ports of elx_exec.
// Assumes a bind onto elx_exec with its two parameters handed on.
module elx_exec_checker
  import elx_pkg::*;
#(
  parameter bit EXT_DATA_EN = 1'b1,
  parameter logic [7:0] NOP_OPC = 8'hff
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Issue and flags
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [7:0] instr_opc,
  input wire logic instr_done,
  input wire logic instr_illegal,
  input wire logic [5:0] flags,
  // External strobes
  input wire logic ext_rd,
  input wire logic ext_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Budget of the opcode taken and cycles since
  logic take;
  logic is_ext;
  logic is_logic;
  logic [4:0] budget;
  logic [4:0] exp_q;
  logic [4:0] cnt_q;
  logic [5:0] flg_q;
  logic ext_q;
  logic logic_q;
  assign take = instr_valid && instr_ready;
  assign is_ext = EXT_DATA_EN && instr_opc[7:5] == 3'h4 && instr_opc[3:1] == 3'h1;
  assign is_logic = (instr_opc[7:4] == OPC_AND_HI || instr_opc[7:4] == OPC_OR_HI)
    && instr_opc[3:0] >= MODE_RR && instr_opc[3:0] <= MODE_IND_IMM;
  assign budget = is_ext ? (instr_opc[0] ? CYC_EXT_AUTOINC : CYC_EXT)
    : is_logic ? (instr_opc[2] ? CYC_LOGIC_REG : CYC_LOGIC_WORK)
    : (instr_opc == NOP_OPC) ? CYC_NOP : CYC_ILLEGAL;
  // Counter saturates so an idle stretch never wraps into a false match
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= 5'h1f;
      exp_q <= 5'h00;
      flg_q <= 6'h00;
      ext_q <= 1'b0;
      logic_q <= 1'b0;
    end else if (take) begin
      cnt_q <= 5'h00;
      exp_q <= budget;
      flg_q <= flags;
      ext_q <= is_ext;
      logic_q <= is_logic;
    end else if (cnt_q != 5'h1f) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_take_load;
    take && is_ext && instr_opc == OPC_EXT_LOAD;
  endsequence
  sequence s_take_store;
    take && is_ext && instr_opc == OPC_EXT_STORE;
  endsequence
  AST_LOAD_BUDGET: assert property (s_take_load |-> ##13 instr_done)
    else $error("load finished off its budget");
  AST_STORE_WRITE: assert property (s_take_store |-> ##[2:13] ext_wr)
    else $error("store gave no write strobe");
  AST_DONE_COUNT: assert property (instr_done |-> cnt_q == exp_q)
    else $error("done after wrong cycle count");
  AST_DONE_BOUND: assert property (take |-> ##[2:20] instr_done)
    else $error("no done after accept");
  AST_ILLEGAL: assert property (take && budget == CYC_ILLEGAL |-> ##2 (instr_done && instr_illegal))
    else $error("unsupported opcode not flagged");
  AST_FLAGS_KEPT: assert property (instr_done && !logic_q |-> flags == flg_q)
    else $error("flags changed by a non-logic operation");
  AST_FLAGS_LOGIC: assert property (instr_done && logic_q |-> !flags[FLG_V]
    && {flags[FLG_H], flags[FLG_D], flags[FLG_C]} == {flg_q[FLG_H], flg_q[FLG_D], flg_q[FLG_C]})
    else $error("logic flags wrong");
  AST_DONE_PULSE: assert property (instr_done |-> instr_ready ##1 !instr_done)
    else $error("done not a single idle pulse");
  AST_EXT_ONLY: assert property ((ext_rd || ext_wr) |-> ext_q && !instr_ready)
    else $error("external strobe outside an external move");
endmodule : elx_exec_checker

// ===== elx_extmem_model.sv
// External data memory seen by the execution unit.
// Assumes registered one-cycle read and write strobes on the core clock.
module elx_extmem_model (
  // Clock
  input wire logic clk,
  // Core side
  input wire logic [15:0] ext_addr,
  input wire logic ext_rd,
  input wire logic ext_wr,
  input wire logic [7:0] ext_wdata,
  output logic [7:0] ext_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [2:0] hold_q;
  initial begin
    ext_rdata = 8'h5a;
    hold_q = 3'h0;
  end
  // Data held six cycles, then toggles so a late sample is caught
  always @(posedge clk) begin
    if (ext_wr) begin
      mem[ext_addr] <= ext_wdata;
    end
    if (ext_rd) begin
      ext_rdata <= mem[ext_addr];
      hold_q <= 3'h6;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end else begin
      ext_rdata <= ~ext_rdata;
    end
  end
endmodule : elx_extmem_model

// ===== test_extdata_load_logic_ops_exec.sv
// Self-checking bench for elx_exec: loads state through the side port,
// issues instructions and compares results. Assumes elx_extmem_model.
module test_extdata_load_logic_ops_exec;
  import elx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] NOP_CODE = 8'hff;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic instr_valid, instr_ready, instr_done, instr_illegal, flags_we, dbg_we, ext_rd, ext_wr;
  logic [7:0] instr_opc, instr_b1, instr_b2, dbg_addr, dbg_wdata, dbg_rdata, ext_wdata, ext_rdata;
  logic [5:0] flags, flags_wdata;
  logic [3:0] work_ptr = 4'h1;
  logic [15:0] ext_addr;
  int fails = 0;
  int tests_run = 0;
  int cyc;
  // Preload address/value, then opcode, b1, b2, destination, result
  logic [15:0] pl [18] = '{16'h1138, 16'h1e8d, 16'h14f9, 16'h1d7b, 16'h7b6a, 16'h3af5,
    16'h420a, 16'h15f0, 16'h4550, 16'h507f, 16'h7af7, 16'h133e, 16'h3eec, 16'h1600,
    16'h1701, 16'h1800, 16'h6080, 16'h6100};
  logic [39:0] lt [12] = '{40'h421e001108, 40'h434d001468, 40'h44423a3a00, 40'h4545e51570,
    40'h467af07af0, 40'h47e3053e04, 40'h026e00168d, 40'h037d00176b, 40'h0442e8180a,
    40'h05456060ff, 40'h0661006100, 40'h07e3f03ef4};
  always #5 clk = ~clk;

  elx_exec #(.EXT_DATA_EN(1'b1), .NOP_OPC(NOP_CODE)) elx_exec_inst (.clk(clk), .rstn(rstn),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_opc(instr_opc),
    .instr_b1(instr_b1), .instr_b2(instr_b2), .work_ptr(work_ptr), .instr_done(instr_done),
    .instr_illegal(instr_illegal), .flags(flags), .flags_we(flags_we),
    .flags_wdata(flags_wdata), .dbg_we(dbg_we), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata),
    .dbg_rdata(dbg_rdata), .ext_addr(ext_addr), .ext_rd(ext_rd), .ext_wr(ext_wr),
    .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));
  elx_extmem_model elx_extmem_model_inst (.clk(clk), .ext_addr(ext_addr), .ext_rd(ext_rd),
    .ext_wr(ext_wr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));

  // ==========================================================================
  // Tasks: each starts and ends 1 ns after a rising edge
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    if (fails == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    dbg_we = 1'b1;
    dbg_addr = a;
    dbg_wdata = d;
    @(posedge clk) #1;
    dbg_we = 1'b0;
    @(posedge clk) #1;
  endtask : wreg
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] v);
    dbg_addr = a;
    @(posedge clk) #1;
    check({8'h00, dbg_rdata}, {8'h00, v});
  endtask : expect_reg
  // Next request goes out right after done, so issues run back to back
  task automatic issue(input logic [7:0] o, input logic [7:0] b1, input logic [7:0] b2);
    instr_valid = 1'b1;
    instr_opc = o;
    instr_b1 = b1;
    instr_b2 = b2;
    @(posedge clk) #1;
    instr_valid = 1'b0;
    cyc = 0;
    do begin
      @(posedge clk) #1;
      cyc++;
    end while (instr_done !== 1'b1 && cyc < 40);
  endtask : issue

  // ==========================================================================
  // Main sequence
  initial begin
    {instr_valid, flags_we, dbg_we, flags_wdata} = 9'h000;
    {instr_opc, instr_b1, instr_b2, dbg_addr, dbg_wdata} = 40'h0;
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    check(16'({instr_ready, instr_illegal, instr_done, flags}), 16'h0100);
    flags_we = 1'b1;
    flags_wdata = 6'h3f;
    @(posedge clk) #1;
    flags_we = 1'b0;
    wreg(8'h16, 8'h40);
    wreg(8'h17, 8'ha2);
    elx_extmem_model_inst.mem[16'h40a2] = 8'h22;
    issue(OPC_EXT_LOAD, 8'h26, 8'h00);
    check(16'(cyc), 16'h000c);
    expect_reg(8'h12, 8'h22);
    wreg(8'h17, 8'h4a);
    issue(OPC_EXT_STORE, 8'h26, 8'h00);
    check(16'(cyc), 16'h000c);
    check({8'h00, elx_extmem_model_inst.mem[16'h404a]}, 16'h0022);
    expect_reg(8'h12, 8'h22);
    wreg(8'h17, 8'hff);
    wreg(8'h12, 8'hff);
    elx_extmem_model_inst.mem[16'h40ff] = 8'hab;
    elx_extmem_model_inst.mem[16'h4100] = 8'hc3;
    issue(OPC_EXT_LOAD_INC, 8'h26, 8'h00);
    check(16'(cyc), 16'h0012);
    issue(OPC_EXT_LOAD_INC, 8'h26, 8'h00);
    expect_reg(8'hff, 8'hab);
    expect_reg(8'h00, 8'hc3);
    expect_reg(8'h12, 8'h01);
    expect_reg(8'h16, 8'h41);
    expect_reg(8'h17, 8'h01);
    wreg(8'h12, 8'h20);
    wreg(8'h20, 8'h5a);
    wreg(8'h16, 8'h12);
    wreg(8'h17, 8'hff);
    issue(OPC_EXT_STORE_INC, 8'h26, 8'h00);
    check(16'(cyc), 16'h0012);
    check({8'h00, elx_extmem_model_inst.mem[16'h12ff]}, 16'h005a);
    expect_reg(8'h12, 8'h21);
    expect_reg(8'h16, 8'h13);
    expect_reg(8'h17, 8'h00);
    check({10'h000, flags}, 16'h003f);
    foreach (pl[i]) begin
      wreg(pl[i][15:8], pl[i][7:0]);
    end
    foreach (lt[i]) begin
      issue(lt[i][39:32], lt[i][31:24], lt[i][23:16]);
      check(16'(cyc), lt[i][34] ? 16'h000a : 16'h0006);
      expect_reg(lt[i][15:8], lt[i][7:0]);
      check({10'h000, flags}, {10'h000, 3'b110, lt[i][7], lt[i][7:0] == 8'h00, 1'b1});
    end
    expect_reg(8'h42, 8'h0a);
    expect_reg(8'h1e, 8'h8d);
    issue(8'h52, 8'h3a, 8'h00);
    check(16'(cyc), 16'h0001);
    check(16'(instr_illegal), 16'h0001);
    expect_reg(8'h3a, 8'h00);
    issue(NOP_CODE, 8'h3e, 8'h3e);
    check(16'(cyc), 16'h0006);
    check(16'(instr_illegal), 16'h0000);
    check({10'h000, flags}, 16'h0035);
    expect_reg(8'h3e, 8'hf4);
    // Another bank: a stale bank would leave register 60h at ffh
    work_ptr = 4'h6;
    wreg(8'h61, 8'h0c);
    issue(8'h42, 8'h01, 8'h00);
    check(16'(cyc), 16'h0006);
    expect_reg(8'h60, 8'h0c);
    results();
  end
  // Whole run is a few hundred cycles; this limit leaves wide margin
  initial begin
    #100000;
    fails++;
    results();
  end
endmodule : test_extdata_load_logic_ops_exec

bind elx_exec elx_exec_checker #(.EXT_DATA_EN(EXT_DATA_EN), .NOP_OPC(NOP_OPC))
  elx_exec_checker_inst (.clk(clk), .rstn(rstn), .instr_valid(instr_valid),
  .instr_ready(instr_ready), .instr_opc(instr_opc), .instr_done(instr_done),
  .instr_illegal(instr_illegal), .flags(flags), .ext_rd(ext_rd), .ext_wr(ext_wr));
